// ==== core/tic_pkg.sv ====
// Constants, register map and carrier types of the trigger input conditioner.
// Assumes one 100 MHz system clock and an APB register port.
package tic_pkg;

   // ==========================================================
   // Input counts
   localparam int N_MAIN = 8;
   localparam int N_FRONT = 4;
   localparam int N_IN = 12;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_FILTER_TIME = 8'h00;
   localparam logic [7:0] OFS_SELECT = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_MAIN_LEVELS = 8'h0C;
   localparam logic [7:0] OFS_FRONT_LEVELS = 8'h10;
   localparam logic [7:0] OFS_FILTERED = 8'h14;

   // ==========================================================
   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SENSE_BIT = 2;
   localparam int FILT_SEL_BIT = 12;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 10000;
   localparam int TICK_PS = 3200;
   localparam int FILTER_TIME_RST_NS = 1000;
   localparam int ACC_W = 22;
   localparam logic [ACC_W-1:0] ACC_TICK = ACC_W'(TICK_PS / 100);
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_PS / 100);
   localparam logic [15:0] FILTER_TIME_RST =
      16'((FILTER_TIME_RST_NS * 1000 + TICK_PS - 1) / TICK_PS);

   // ==========================================================
   // Source selection codes
   localparam logic [3:0] MAIN_INPUT_ZERO_CHOICE = 4'h0;
   localparam logic [3:0] FRONT_INPUT_ZERO_CHOICE = 4'h8;
   localparam logic [3:0] SELECT_MAX = 4'hB;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      TIC_MODE_GENERATOR,
      TIC_MODE_EXTERNAL,
      TIC_MODE_SOFTWARE,
      TIC_MODE_SYNCHRONIZED
   } tic_mode_e;

   typedef enum logic {
      TIC_SENSE_LOW_ACTIVE,
      TIC_SENSE_HIGH_ACTIVE
   } tic_sense_e;

   typedef struct packed {
      logic [15:0] filter_time;
      logic [3:0] select;
      tic_mode_e mode;
      tic_sense_e sense;
   } tic_cfg_s;

   typedef struct packed {
      logic [N_FRONT-1:0] front;
      logic [N_MAIN-1:0] main;
   } tic_lvl_s;

endpackage : tic_pkg

// ==== core/tic_conditioner.sv ====
// Trigger input conditioner: glitch filters, level snapshots, source select.
// Assumes external trigger pins asynchronous to CLK_SYS, APB master on CLK_SYS.
//
// Summary of operation
// - Accept level change only after stable time
// - Time programmable 0 to 209.712 us, reset 1.0
// - Accepted edge delayed by programmed time
// - One time setting filters all inputs
// - Setting global, last write applies everywhere
// - Main levels readable, bit n input n
// - Front levels readable, bit n input n
// - Selector routes one of twelve, reset main0
// - Non-external mode feeds statistics only
// - Programmable active level on selected source
// - Statistics tap after filter and sense
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.

// ==========================================================
// Single input glitch filter
module tic_glitch_filter (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic level_in,
   input wire logic [tic_pkg::ACC_W-1:0] thr,
   output logic level_out
);

   logic [tic_pkg::ACC_W-1:0] acc;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         acc <= '0;
         level_out <= 1'b0;
      end else if (level_in == level_out) begin
         acc <= '0;
      end else if (acc >= thr) begin
         level_out <= level_in;
         acc <= '0;
      end else begin
         acc <= acc + tic_pkg::ACC_STEP;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   property p_spike_reject;
      $changed(level_out) |-> $past(acc) >= $past(thr) && $past(level_in) == level_out;
   endproperty
   a_spike_reject: assert property (p_spike_reject)
      else $error("Filtered level changed before stable time");

   property p_acc_bound;
      acc != '0 |-> $past(acc) < $past(thr) && $past(level_in) != $past(level_out);
   endproperty
   a_acc_bound: assert property (p_acc_bound)
      else $error("Filter counter ran past threshold");

   sequence s_unstable;
      level_in != level_out && acc < thr;
   endsequence
   property p_latency;
      s_unstable ##0 $stable(thr) |=> $stable(level_out);
   endproperty
   a_latency: assert property (p_latency)
      else $error("Level accepted before programmed delay");

endmodule : tic_glitch_filter

// ==========================================================
// Top level
module tic_conditioner (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [tic_pkg::N_MAIN-1:0] MAIN_IN,
   input wire logic [tic_pkg::N_FRONT-1:0] FRONT_IN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic TRIG_OUT,
   output logic STAT_OUT
);

   tic_pkg::tic_cfg_s cfg;
   logic [15:0] filter_time;
   logic [3:0] select;
   tic_pkg::tic_mode_e mode;
   tic_pkg::tic_sense_e sense;
   tic_pkg::tic_lvl_s sync1;
   tic_pkg::tic_lvl_s sync2;
   tic_pkg::tic_lvl_s snap;
   logic [tic_pkg::N_IN-1:0] filt;
   logic [tic_pkg::ACC_W-1:0] thr;
   logic sel_lvl;
   logic cond_lvl;
   logic wr_en;
   logic setup;
   logic [31:0] next_rdata;
   logic next_err;

   // ==========================================================
   // Input synchronizers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {FRONT_IN, MAIN_IN};
         sync2 <= sync1;
      end
   end

   // ==========================================================
   // Level snapshots
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         snap <= '0;
      end else begin
         snap <= sync2;
      end
   end

   // ==========================================================
   // Glitch filters
   assign thr = tic_pkg::ACC_W'(cfg.filter_time) * tic_pkg::ACC_TICK;

   for (genvar gi = 0; gi < tic_pkg::N_IN; gi++) begin : g_filt
      tic_glitch_filter u_filt (
         .CLK_SYS(CLK_SYS),
         .RST_N(RST_N),
         .level_in(sync2[gi]),
         .thr(thr),
         .level_out(filt[gi])
      );
   end

   // ==========================================================
   // Source select and sense
   always_comb begin
      sel_lvl = filt[cfg.select];
      cond_lvl = (cfg.sense == tic_pkg::TIC_SENSE_HIGH_ACTIVE) ? sel_lvl : ~sel_lvl;
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         STAT_OUT <= 1'b0;
         TRIG_OUT <= 1'b0;
      end else begin
         STAT_OUT <= cond_lvl;
         TRIG_OUT <= cond_lvl && (cfg.mode == tic_pkg::TIC_MODE_EXTERNAL);
      end
   end

   // ==========================================================
   // APB slave
   assign setup = PSEL && !PENABLE;
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign PREADY = 1'b1;
   assign cfg = '{filter_time: filter_time, select: select, mode: mode, sense: sense};

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         filter_time <= tic_pkg::FILTER_TIME_RST;
      end else if (wr_en && PADDR == tic_pkg::OFS_FILTER_TIME) begin
         filter_time <= PWDATA[15:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         select <= tic_pkg::MAIN_INPUT_ZERO_CHOICE;
      end else if (wr_en && PADDR == tic_pkg::OFS_SELECT) begin
         if (PWDATA[3:0] <= tic_pkg::SELECT_MAX && PWDATA[31:4] == '0) begin
            select <= PWDATA[3:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mode <= tic_pkg::TIC_MODE_GENERATOR;
         sense <= tic_pkg::TIC_SENSE_HIGH_ACTIVE;
      end else if (wr_en && PADDR == tic_pkg::OFS_CONTROL) begin
         mode <= tic_pkg::tic_mode_e'(PWDATA[tic_pkg::CTRL_MODE_LSB +: 2]);
         sense <= tic_pkg::tic_sense_e'(PWDATA[tic_pkg::CTRL_SENSE_BIT]);
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      next_err = 1'b0;
      unique case (PADDR)
         tic_pkg::OFS_FILTER_TIME: begin
            next_rdata[15:0] = cfg.filter_time;
         end
         tic_pkg::OFS_SELECT: begin
            next_rdata[3:0] = cfg.select;
         end
         tic_pkg::OFS_CONTROL: begin
            next_rdata[tic_pkg::CTRL_MODE_LSB +: 2] = cfg.mode;
            next_rdata[tic_pkg::CTRL_SENSE_BIT] = cfg.sense;
         end
         tic_pkg::OFS_MAIN_LEVELS: begin
            next_rdata[7:0] = snap.main;
            next_err = PWRITE;
         end
         tic_pkg::OFS_FRONT_LEVELS: begin
            next_rdata[3:0] = snap.front;
            next_err = PWRITE;
         end
         tic_pkg::OFS_FILTERED: begin
            next_rdata[tic_pkg::N_IN-1:0] = filt;
            next_rdata[tic_pkg::FILT_SEL_BIT] = cond_lvl;
            next_err = PWRITE;
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PRDATA <= next_rdata;
         PSLVERR <= next_err;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   property p_time_write;
      wr_en && PADDR == tic_pkg::OFS_FILTER_TIME |=> cfg.filter_time == $past(PWDATA[15:0]);
   endproperty
   a_time_write: assert property (p_time_write)
      else $error("Filter time write not applied");

   property p_time_hold;
      !(wr_en && PADDR == tic_pkg::OFS_FILTER_TIME) |=> $stable(cfg.filter_time);
   endproperty
   a_time_hold: assert property (p_time_hold)
      else $error("Filter time changed without write");

   property p_main_snap;
      ##3 snap.main == $past(MAIN_IN, 3);
   endproperty
   a_main_snap: assert property (p_main_snap)
      else $error("Main level snapshot wrong");

   property p_front_snap;
      ##3 snap.front == $past(FRONT_IN, 3);
   endproperty
   a_front_snap: assert property (p_front_snap)
      else $error("Front level snapshot wrong");

   property p_sel_range;
      cfg.select <= tic_pkg::SELECT_MAX;
   endproperty
   a_sel_range: assert property (p_sel_range)
      else $error("Source select out of range");

   property p_sel_ignore;
      wr_en && PADDR == tic_pkg::OFS_SELECT && PWDATA > 32'(tic_pkg::SELECT_MAX)
         |=> $stable(cfg.select);
   endproperty
   a_sel_ignore: assert property (p_sel_ignore)
      else $error("Out of range source select accepted");

   property p_gate;
      cfg.mode != tic_pkg::TIC_MODE_EXTERNAL |=> !TRIG_OUT;
   endproperty
   a_gate: assert property (p_gate)
      else $error("Trigger produced outside external mode");

   sequence s_sense_low;
      cfg.sense == tic_pkg::TIC_SENSE_LOW_ACTIVE;
   endsequence
   property p_sense;
      s_sense_low |=> STAT_OUT == !$past(filt[cfg.select]);
   endproperty
   a_sense: assert property (p_sense)
      else $error("Low active sense not applied");

   property p_tap;
      1'b1 |=> STAT_OUT == $past(cond_lvl) && (TRIG_OUT -> STAT_OUT);
   endproperty
   a_tap: assert property (p_tap)
      else $error("Statistics tap mismatch");

   property p_external;
      cfg.mode == tic_pkg::TIC_MODE_EXTERNAL |=> TRIG_OUT == $past(cond_lvl);
   endproperty
   a_external: assert property (p_external)
      else $error("External trigger not forwarded");

   property p_read;
      setup && PADDR == tic_pkg::OFS_MAIN_LEVELS |=> PRDATA == {24'h000000, $past(snap.main)};
   endproperty
   a_read: assert property (p_read)
      else $error("Main level read data wrong");

endmodule : tic_conditioner

// ==== bench/tic_source_model.sv ====
// Behavioural trigger source that drives the wanted pin levels with contact bounce.
// Assumes the bench changes the wanted levels just after a rising clock edge.
module tic_source_model (
   input wire logic CLK_SYS,
   input wire tic_pkg::tic_lvl_s want,
   output tic_pkg::tic_lvl_s pins
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Bounce generator
   logic [11:0] goal = 12'h000;
   logic [11:0] flip = 12'h000;
   logic [2:0] left = 3'h0;

   // Changed pins toggle between old and new level for five cycles, then settle
   always @(posedge CLK_SYS) begin
      if (want !== goal) begin
         flip <= want ^ goal;
         goal <= want;
         left <= 3'h5;
      end else if (left != 3'h0) begin
         left <= left - 3'h1;
      end
   end

   assign pins = goal ^ (left[0] ? flip : 12'h000);

endmodule : tic_source_model

// ==== bench/tic_conditioner_tb.sv ====
// Self-checking bench of the trigger input conditioner.
// Assumes tic_pkg, the design and tic_source_model are compiled before it.
module tic_conditioner_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   logic CLK_SYS = 1'b0;
   logic RST_N = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h00000000;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic TRIG_OUT;
   logic STAT_OUT;
   tic_pkg::tic_lvl_s want = '0;
   tic_pkg::tic_lvl_s pins;
   logic probe = 1'b0;
   logic [31:0] q[$];
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_cyc = 0;
   int seed = 31692;
   logic [1:0] mode;
   logic sense;

   always #5 CLK_SYS = ~CLK_SYS;

   tic_source_model src (
      .CLK_SYS(CLK_SYS),
      .want(want),
      .pins(pins)
   );

   tic_conditioner dut (
      .CLK_SYS(CLK_SYS),
      .RST_N(RST_N),
      .MAIN_IN(pins.main),
      .FRONT_IN(pins.front),
      .PSEL(PSEL),
      .PENABLE(PENABLE),
      .PWRITE(PWRITE),
      .PADDR(PADDR),
      .PWDATA(PWDATA),
      .PRDATA(PRDATA),
      .PREADY(PREADY),
      .PSLVERR(PSLVERR),
      .TRIG_OUT(TRIG_OUT),
      .STAT_OUT(STAT_OUT)
   );

   // ==========================================================
   // Tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task end_sim();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask : cyc

   // Expected value: read data, or error flag for a write
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
      q.push_back(e);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PADDR <= a;
      PWRITE <= w;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      do @(posedge CLK_SYS); while (PREADY !== 1'b1);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK_SYS);
   endtask : apb

   task probe_out(input logic [1:0] e);
      q.push_back({30'h0, e});
      probe <= 1'b1;
      @(posedge CLK_SYS);
      probe <= 1'b0;
      @(posedge CLK_SYS);
   endtask : probe_out

   // ==========================================================
   // Monitor and timeout
   always @(posedge CLK_SYS) begin
      if ((PSEL && PENABLE && PREADY === 1'b1) || probe) begin
         if (q.size() == 0)
            chk(32'h1, 32'h0);
         else if (probe)
            chk({30'h0, TRIG_OUT, STAT_OUT}, q.pop_front());
         else
            chk(PWRITE ? {31'h0, PSLVERR} : PRDATA, q.pop_front());
      end
      n_cyc++;
      if (n_cyc == 30000) begin
         n_mismatch++;
         end_sim();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      cyc(16);
      RST_N <= 1'b1;
      @(posedge CLK_SYS);
      apb(tic_pkg::OFS_FILTER_TIME, 1'b0, 32'h0, {16'h0, tic_pkg::FILTER_TIME_RST});
      apb(tic_pkg::OFS_SELECT, 1'b0, 32'h0, {28'h0, tic_pkg::MAIN_INPUT_ZERO_CHOICE});
      apb(tic_pkg::OFS_CONTROL, 1'b0, 32'h0, 32'h1 << tic_pkg::CTRL_SENSE_BIT);
      apb(8'h40, 1'b1, 32'hF, 32'h1);
      apb(8'h40, 1'b0, 32'h0, 32'h0);
      apb(tic_pkg::OFS_MAIN_LEVELS, 1'b1, 32'hFF, 32'h1);
      apb(tic_pkg::OFS_FILTER_TIME, 1'b1, 32'hA, 32'h0);
      repeat (4) begin
         want <= 12'($random(seed));
         cyc(12);
         apb(tic_pkg::OFS_MAIN_LEVELS, 1'b0, 32'h0, {24'h0, want.main});
         apb(tic_pkg::OFS_FRONT_LEVELS, 1'b0, 32'h0, {28'h0, want.front});
      end
      for (int i = 0; i < 12; i++) begin
         mode = 2'(i % 4);
         sense = (i / 4) != 1;
         apb(tic_pkg::OFS_SELECT, 1'b1, 32'(i), 32'h0);
         apb(tic_pkg::OFS_CONTROL, 1'b1, {29'h0, sense, mode}, 32'h0);
         want <= ~(12'h001 << i);
         cyc(24);
         probe_out({mode == 2'h1 && !sense, !sense});
         apb(tic_pkg::OFS_FILTERED, 1'b0, 32'h0, {19'h0, !sense, ~(12'h001 << i)});
         want <= 12'hFFF;
         cyc(6);
         probe_out({mode == 2'h1 && !sense, !sense});
         cyc(14);
         probe_out({mode == 2'h1 && sense, sense});
      end
      apb(tic_pkg::OFS_SELECT, 1'b1, 32'hC, 32'h0);
      apb(tic_pkg::OFS_SELECT, 1'b0, 32'h0, {28'h0, tic_pkg::SELECT_MAX});
      end_sim();
   end

endmodule : tic_conditioner_tb
